// [verilog/dps_core.sv]
// Dual loop synthesizer core: serial loader, latches and two loops
`timescale 1ns/1ns
`default_nettype none
// Contract
// RULE_01: Serial clock rise shifts one data bit
// RULE_02: Last bit one picks loop 1, zero loop 2
// RULE_03: Next-to-last bit sets steered switch output
// RULE_04: Third-last bit: zero feedback, one reference latch
// RULE_05: Feedback words 20 bits, or 24 padded
// RULE_06: Reference words 17 bits, or 24 padded
// RULE_07: Strobe pulse copies word into selected latch
// RULE_08: Shifting with strobe low changes no latch
// RULE_09: Host raises strobe only after whole word
// RULE_10: VCO edge decrements main and active swallow
// RULE_11: Detector pulses low leading, high lagging, else off
// RULE_12: Modulus select low until swallow expires, reload
// RULE_13: Lock flag high in lock, pulses low otherwise
// RULE_14: Reference divider divides oscillator by latched value
// RULE_15: Divider bits first, MSB first, then control
module dps_core (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_serial_clock,
    input  wire logic i_serial_data,
    input  wire logic i_latch_strobe,
    input  wire logic i_reference_osc_input,
    input  wire logic i_vco_feedback_input_1,
    input  wire logic i_vco_feedback_input_2,
    input  wire logic i_open_drain_switch_1,
    input  wire logic i_open_drain_switch_2,
    output logic      o_open_drain_switch_1,
    output logic      o_open_drain_switch_1_oe,
    output logic      o_open_drain_switch_2,
    output logic      o_open_drain_switch_2_oe,
    output logic      o_phase_error_output_1,
    output logic      o_phase_error_output_1_oe,
    output logic      o_phase_error_output_2,
    output logic      o_phase_error_output_2_oe,
    output logic      o_prescaler_modulus_select_1,
    output logic      o_prescaler_modulus_select_2,
    output logic      o_loop_lock_flag_1,
    output logic      o_loop_lock_flag_2,
    output logic      o_serial_shift_word
);
    localparam int PIN_N = dps_pkg::PIN_N;
    localparam int SR_W = dps_pkg::SR_W;
    localparam int R_W = dps_pkg::R_W;
    localparam int N_W = dps_pkg::N_W;
    localparam int A_W = dps_pkg::A_W;
    // Pin vector positions
    localparam int P_SCLK = 0;
    localparam int P_SDATA = 1;
    localparam int P_STB = 2;
    localparam int P_OSC = 3;
    localparam int P_VCO1 = 4;
    // Pins must hold each level two clocks to be seen

    // Hold the last level until both later stages agree
    function automatic logic [PIN_N-1:0] settle(
        input logic [PIN_N-1:0] a,
        input logic [PIN_N-1:0] b,
        input logic [PIN_N-1:0] last
    );
        return (a & b) | (last & (a | b));
    endfunction

    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] s1_q, s2_q, s3_q;
    logic [PIN_N-1:0] lvl_q, lvl_d;
    logic [PIN_N-1:0] rise;

    logic [SR_W-1:0]  sr_q, sr_d;
    logic [R_W-1:0]   r_q [2];
    logic [R_W-1:0]   r_d [2];
    logic [N_W-1:0]   n_q [2];
    logic [N_W-1:0]   n_d [2];
    logic [A_W-1:0]   a_q [2];
    logic [A_W-1:0]   a_d [2];
    logic [1:0]       sw_q, sw_d;
    logic             sel_idx;

    logic [1:0]       modsel;
    logic [1:0]       pd_level;
    logic [1:0]       pd_oe;
    logic [1:0]       lock;

    // Ignoring the unused open-drain readback is deliberate
    logic [1:0]       sw_pin_unused;
    assign sw_pin_unused = {i_open_drain_switch_2, i_open_drain_switch_1};

    // Every pin comes from a clock unrelated to ours
    assign pin_raw = {i_vco_feedback_input_2,
                      i_vco_feedback_input_1,
                      i_reference_osc_input,
                      i_latch_strobe,
                      i_serial_data,
                      i_serial_clock};

    // A level counts once the second and third stages agree
    always_comb begin
        lvl_d = settle(s2_q, s3_q, lvl_q);
        rise = lvl_d & ~lvl_q;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
        end else begin
            // First stage may go metastable; only the second reads it
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    // Shift register: one bit per recognised serial clock rise
    always_comb begin
        sr_d = sr_q;
        // Data is already settled when the clock edge is seen
        if (rise[P_SCLK]) begin
            sr_d = {sr_q[SR_W-2:0], lvl_q[P_SDATA]}; // RULE_01 RULE_15
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sr_q <= '0;
        end else begin
            sr_q <= sr_d;
        end
    end

    // Steering and switch latches
    always_comb begin
        sw_d = sw_q;
        // Last bit one steers to loop 1 (index 0)
        sel_idx = ~sr_q[dps_pkg::BIT_STEER]; // RULE_02
        // Strobe and shift in one cycle: the older word is latched
        if (rise[P_STB]) begin // RULE_07 RULE_08 RULE_09
            sw_d[sel_idx] = sr_q[dps_pkg::BIT_SW]; // RULE_03
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            // Released at power-up so no switch load is pulled
            sw_q <= {2{dps_pkg::SW_RST}};
        end else begin
            sw_q <= sw_d;
        end
    end

    // Divider latches; counters take new values at their next reload
    always_comb begin
        r_d = r_q;
        n_d = n_q;
        a_d = a_q;
        if (rise[P_STB]) begin // RULE_07 RULE_08
            if (sr_q[dps_pkg::BIT_SEL]) begin // RULE_04
                // Bits above the 17-bit word are don't-care
                r_d[sel_idx] = sr_q[dps_pkg::BIT_VAL_LO +: R_W]; // RULE_06
            end else begin
                // Bits above the 20-bit word are don't-care
                n_d[sel_idx] = sr_q[dps_pkg::N_LO +: N_W]; // RULE_05
                a_d[sel_idx] = sr_q[dps_pkg::A_LO +: A_W]; // RULE_05
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 2; k++) begin
                r_q[k] <= dps_pkg::R_RST;
                n_q[k] <= dps_pkg::N_RST;
                a_q[k] <= dps_pkg::A_RST;
            end
        end else begin
            r_q <= r_d;
            n_q <= n_d;
            a_q <= a_d;
        end
    end

    // Both loops share the reference oscillator edge
    for (genvar g = 0; g < 2; g++) begin : g_loop
        dps_loop #(
            .R_W (R_W),
            .N_W (N_W),
            .A_W (A_W)
        ) i_dps_loop (
            .i_clk      (i_clk),
            .i_rst      (i_rst),
            .i_osc_rise (rise[P_OSC]),
            .i_vco_rise (rise[P_VCO1 + g]), // RULE_10
            .i_ref_div  (r_q[g]),
            .i_main_div (n_q[g]),
            .i_swal_div (a_q[g]),
            .o_modsel   (modsel[g]),
            .o_pd_level (pd_level[g]),
            .o_pd_oe    (pd_oe[g]),
            .o_lock     (lock[g])
        );
    end

    // Open drain: only ever pulls low
    assign o_open_drain_switch_1 = 1'b0;
    assign o_open_drain_switch_2 = 1'b0;
    assign o_open_drain_switch_1_oe = ~sw_q[0]; // RULE_03
    assign o_open_drain_switch_2_oe = ~sw_q[1]; // RULE_03
    // Detector, modulus and lock levels come straight from loop flops
    assign o_phase_error_output_1 = pd_level[0];
    assign o_phase_error_output_1_oe = pd_oe[0];
    assign o_phase_error_output_2 = pd_level[1];
    assign o_phase_error_output_2_oe = pd_oe[1];
    assign o_prescaler_modulus_select_1 = modsel[0];
    assign o_prescaler_modulus_select_2 = modsel[1];
    assign o_loop_lock_flag_1 = lock[0];
    assign o_loop_lock_flag_2 = lock[1];
    // Oldest shift bit, for chaining or checking the bit stream
    assign o_serial_shift_word = sr_q[SR_W-1];
endmodule
`default_nettype wire

// [shared/dps_pkg.sv]
// Shared constants for the dual loop synthesizer serial core
package dps_pkg;
    // Divider and shift register widths
    localparam int R_W = 14;
    localparam int N_W = 10;
    localparam int A_W = 7;
    localparam int SR_W = 24;
    // Word layout, bit 0 is the last bit shifted in
    localparam int BIT_STEER = 0;
    localparam int BIT_SW = 1;
    localparam int BIT_SEL = 2;
    localparam int BIT_VAL_LO = 3;
    localparam int FB_WORD_BITS = 20;
    localparam int REF_WORD_BITS = 17;
    localparam int A_LO = BIT_VAL_LO;
    localparam int N_LO = BIT_VAL_LO + A_W;
    // Number of pin inputs passed through the synchroniser
    localparam int PIN_N = 6;
    // Values after reset
    localparam logic [R_W-1:0] R_RST = 14'h0008;
    localparam logic [N_W-1:0] N_RST = 10'h008;
    localparam logic [A_W-1:0] A_RST = 7'h00;
    localparam logic SW_RST = 1'h1;
endpackage

// [verilog/dps_loop.sv]
// One synthesizer loop: reference divider, feedback counters, detector
`timescale 1ns/1ns
`default_nettype none
module dps_loop #(
    parameter int R_W = dps_pkg::R_W,
    parameter int N_W = dps_pkg::N_W,
    parameter int A_W = dps_pkg::A_W
) (
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    input  wire logic           i_osc_rise,
    input  wire logic           i_vco_rise,
    input  wire logic [R_W-1:0] i_ref_div,
    input  wire logic [N_W-1:0] i_main_div,
    input  wire logic [A_W-1:0] i_swal_div,
    output logic                o_modsel,
    output logic                o_pd_level,
    output logic                o_pd_oe,
    output logic                o_lock
);
    logic [R_W-1:0] r_cnt_q, r_cnt_d;
    logic [N_W-1:0] n_cnt_q, n_cnt_d;
    logic [A_W-1:0] a_cnt_q, a_cnt_d;
    logic           modsel_q, modsel_d;
    logic           up_q, up_d;
    logic           dn_q, dn_d;
    logic           pd_q, pd_d;
    logic           pdoe_q, pdoe_d;
    logic           lock_q, lock_d;
    logic           ref_evt;
    logic           fb_evt;

    always_comb begin
        r_cnt_d = r_cnt_q;
        ref_evt = 1'b0;
        if (i_osc_rise) begin
            // Divide by the latched value; end of period reloads
            if (r_cnt_q <= R_W'(1)) begin
                r_cnt_d = i_ref_div; // RULE_14
                ref_evt = 1'b1;
            end else begin
                r_cnt_d = r_cnt_q - 1'b1; // RULE_14
            end
        end

        n_cnt_d = n_cnt_q;
        a_cnt_d = a_cnt_q;
        fb_evt = 1'b0;
        if (i_vco_rise) begin
            if (n_cnt_q <= N_W'(1)) begin
                // Main counter expired: both counters reload
                n_cnt_d = i_main_div; // RULE_12
                a_cnt_d = i_swal_div; // RULE_12
                fb_evt = 1'b1;
            end else begin
                n_cnt_d = n_cnt_q - 1'b1; // RULE_10
                if (a_cnt_q != '0) begin
                    a_cnt_d = a_cnt_q - 1'b1; // RULE_10
                end
            end
        end
        // Low while swallow counter runs, high afterwards
        modsel_d = (a_cnt_d == '0); // RULE_12

        // Three-state phase/frequency detector
        up_d = up_q | ref_evt;
        dn_d = dn_q | fb_evt;
        if (up_d && dn_d) begin
            // A fresh edge that lands with the reset is kept
            up_d = up_q & ref_evt;
            dn_d = dn_q & fb_evt;
        end
        // Lagging feedback drives high, leading drives low
        pd_d = up_d; // RULE_11
        pdoe_d = up_d ^ dn_d; // RULE_11
        lock_d = ~(up_d | dn_d); // RULE_13
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            r_cnt_q <= R_W'(dps_pkg::R_RST);
            n_cnt_q <= N_W'(dps_pkg::N_RST);
            a_cnt_q <= A_W'(dps_pkg::A_RST);
            modsel_q <= 1'b0;
            up_q <= 1'b0;
            dn_q <= 1'b0;
            pd_q <= 1'b0;
            pdoe_q <= 1'b0;
            lock_q <= 1'b1;
        end else begin
            r_cnt_q <= r_cnt_d;
            n_cnt_q <= n_cnt_d;
            a_cnt_q <= a_cnt_d;
            modsel_q <= modsel_d;
            up_q <= up_d;
            dn_q <= dn_d;
            pd_q <= pd_d;
            pdoe_q <= pdoe_d;
            lock_q <= lock_d;
        end
    end

    assign o_modsel = modsel_q;
    assign o_pd_level = pd_q;
    assign o_pd_oe = pdoe_q;
    assign o_lock = lock_q;
endmodule
`default_nettype wire

// [bench/dps_core_sva.sv]
// Assertion checker for the dual loop synthesizer core
`timescale 1ns/1ns
`default_nettype none
module dps_core_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_serial_clock,
    input wire logic i_latch_strobe,
    input wire logic i_vco_feedback_input_1,
    input wire logic i_vco_feedback_input_2,
    input wire logic o_open_drain_switch_1,
    input wire logic o_open_drain_switch_2,
    input wire logic o_open_drain_switch_1_oe,
    input wire logic o_open_drain_switch_2_oe,
    input wire logic o_phase_error_output_1_oe,
    input wire logic o_phase_error_output_2_oe,
    input wire logic o_prescaler_modulus_select_1,
    input wire logic o_prescaler_modulus_select_2,
    input wire logic o_loop_lock_flag_1,
    input wire logic o_loop_lock_flag_2,
    input wire logic o_serial_shift_word
);
    // Cycles since a pin moved; outputs may only follow pin activity
    logic [3:0] cs_q, ce_q, cv_q;
    function automatic logic [3:0] quiet(input logic c, input logic [3:0] q);
        return c ? 4'h0 : q + {3'h0, q != 4'hF};
    endfunction
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {cs_q, ce_q, cv_q} <= 12'h000;
        end else begin
            cs_q <= quiet($changed(i_serial_clock), cs_q);
            ce_q <= quiet($changed(i_latch_strobe), ce_q);
            cv_q <= quiet($changed(i_vco_feedback_input_1)
                || $changed(i_vco_feedback_input_2), cv_q);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_lk1;
        o_loop_lock_flag_1 != o_phase_error_output_1_oe; endproperty
    a_lk1: assert property (p_lk1) else $error("lock 1 off");
    property p_lk2;
        o_loop_lock_flag_2 != o_phase_error_output_2_oe; endproperty
    a_lk2: assert property (p_lk2) else $error("lock 2 off");
    property p_sw1;
        ce_q > 4'h6 |-> $stable(o_open_drain_switch_1_oe); endproperty
    a_sw1: assert property (p_sw1) else $error("switch 1 moved");
    property p_sw2;
        ce_q > 4'h6 |-> $stable(o_open_drain_switch_2_oe); endproperty
    a_sw2: assert property (p_sw2) else $error("switch 2 moved");
    property p_md1;
        cv_q > 4'h6 |-> $stable(o_prescaler_modulus_select_1); endproperty
    a_md1: assert property (p_md1) else $error("modsel 1 moved");
    property p_md2;
        cv_q > 4'h6 |-> $stable(o_prescaler_modulus_select_2); endproperty
    a_md2: assert property (p_md2) else $error("modsel 2 moved");
    property p_sh;
        cs_q > 4'h6 |-> $stable(o_serial_shift_word); endproperty
    a_sh: assert property (p_sh) else $error("shift out moved");
    property p_od;
        o_open_drain_switch_1 == 1'b0; endproperty
    a_od: assert property (p_od) else $error("switch drives high");
    property p_od2;
        o_open_drain_switch_2 == 1'b0; endproperty
    a_od2: assert property (p_od2) else $error("switch 2 high");
endmodule
bind dps_core dps_core_sva i_dps_core_sva (.*);
`default_nettype wire

// [bench/dps_host.sv]
// Host serial port model that loads the synthesizer core
`timescale 1ns/1ns
`default_nettype none
module dps_host (
    input  wire logic i_clk,
    output logic      o_sclk,
    output logic      o_sdata,
    output logic      o_strobe
);
    initial {o_sclk, o_sdata, o_strobe} = 3'h0;
    task automatic tick();
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    // Low n bits of w, oldest first; clock idles low between words
    task automatic send(input logic [23:0] w, input int n, input logic go);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdata = w[i];
            tick();
            o_sclk = 1'b1;
            tick();
            o_sclk = 1'b0;
        end
        // Released line shows the inverse, never a stale bit
        o_sdata = ~o_sdata;
        tick();
        if (go) begin
            o_strobe = 1'b1;
            tick();
            o_strobe = 1'b0;
            tick();
        end
    endtask
endmodule
`default_nettype wire

// [bench/dps_core_tb.sv]
// Self-checking bench for the dual loop synthesizer core
`timescale 1ns/1ns
`default_nettype none
module dps_core_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_serial_clock, i_serial_data, i_latch_strobe;
    logic i_reference_osc_input, i_vco_feedback_input_1;
    logic i_vco_feedback_input_2, i_open_drain_switch_1;
    logic i_open_drain_switch_2, o_open_drain_switch_1;
    logic o_open_drain_switch_2, o_open_drain_switch_1_oe;
    logic o_open_drain_switch_2_oe, o_phase_error_output_1;
    logic o_phase_error_output_2, o_phase_error_output_1_oe;
    logic o_phase_error_output_2_oe, o_prescaler_modulus_select_1;
    logic o_prescaler_modulus_select_2, o_loop_lock_flag_1;
    logic o_loop_lock_flag_2, o_serial_shift_word;
    logic [2:0] pins = 3'h0;
    logic [7:0] hi1, hi2;
    logic [1:0] seen1, seen2;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2 i_clk = ~i_clk;
    assign {i_reference_osc_input, i_vco_feedback_input_2,
        i_vco_feedback_input_1} = pins;
    // Pull-ups hold the open-drain pins high when released
    assign i_open_drain_switch_1 = ~o_open_drain_switch_1_oe;
    assign i_open_drain_switch_2 = ~o_open_drain_switch_2_oe;
    dps_core i_dps_core (.*);
    dps_host i_dps_host (
        .i_clk    (i_clk),
        .o_sclk   (i_serial_clock),
        .o_sdata  (i_serial_data),
        .o_strobe (i_latch_strobe)
    );
    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Square pulses on the selected pins, modsel sampled after each
    task automatic pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            pins = m;
            repeat (4) @(posedge i_clk);
            #1 pins = 3'h0;
            repeat (4) @(posedge i_clk);
            #1 hi1 += {7'h00, o_prescaler_modulus_select_1};
            hi2 += {7'h00, o_prescaler_modulus_select_2};
        end
    endtask
    // Sampled mid-cycle, where registered outputs have settled
    always @(negedge i_clk) begin
        cyc++;
        if (o_phase_error_output_1_oe === 1'b1)
            seen1[o_phase_error_output_1] = 1'b1;
        if (o_phase_error_output_2_oe === 1'b1)
            seen2[o_phase_error_output_2] = 1'b1;
        // Whole run needs about 1140 cycles
        if (cyc == 10000) begin
            errors++;
            results();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        #1 i_rst = 1'b0;
        i_dps_host.send({4'h0, 10'h005, 7'h02, 3'h1}, 20, 1'b1);
        chk("sw1 oe", 8'h01, {7'h00, o_open_drain_switch_1_oe});
        chk("sw2 oe", 8'h00, {7'h00, o_open_drain_switch_2_oe});
        $display("test 1 done");
        // Reference word for loop 2 with 7 pad bits
        i_dps_host.send({7'h7F, 14'h0013, 3'h4}, 24, 1'b0);
        chk("shift out", 8'h01, {7'h00, o_serial_shift_word});
        i_dps_host.send(24'h000000, 0, 1'b1);
        chk("sw2 oe", 8'h01, {7'h00, o_open_drain_switch_2_oe});
        chk("sw1 oe", 8'h01, {7'h00, o_open_drain_switch_1_oe});
        $display("test 2 done");
        i_dps_host.send({4'hF, 10'h005, 7'h02, 3'h3}, 24, 1'b0);
        chk("sw1 oe", 8'h01, {7'h00, o_open_drain_switch_1_oe});
        chk("shift out", 8'h01, {7'h00, o_serial_shift_word});
        i_dps_host.send(24'h000000, 0, 1'b1);
        chk("sw1 oe", 8'h00, {7'h00, o_open_drain_switch_1_oe});
        $display("test 3 done");
        // Flush the reset-time counts before measuring
        pulse(3'h3, 8);
        {hi1, hi2, seen1, seen2} = 20'h00000;
        pulse(3'h3, 20);
        chk("modsel 1 highs", 8'h0C, hi1);
        chk("modsel 2 highs", 8'h14, hi2);
        chk("pd1 signs", 8'h01, {6'h00, seen1});
        chk("pd2 signs", 8'h01, {6'h00, seen2});
        $display("test 4 done");
        pulse(3'h4, 20);
        {seen1, seen2} = 4'h0;
        pulse(3'h4, 20);
        chk("pd1 signs", 8'h02, {6'h00, seen1});
        chk("pd2 signs", 8'h02, {6'h00, seen2});
        chk("lock 1", 8'h00, {7'h00, o_loop_lock_flag_1});
        chk("lock 2", 8'h00, {7'h00, o_loop_lock_flag_2});
        $display("test 5 done");
        results();
    end
endmodule
`default_nettype wire
